// ---- src/gpc_cfg.svh ----
// Register offsets, field positions, reset values for the pin 6/7 control.
// Assumes inclusion by bare name from files under src/.
`ifndef GPC_CFG_SVH
`define GPC_CFG_SVH
// ****************************************************************
// Register map
// ****************************************************************
`define GPC_OFS_PIN6_CONTROL 8'h24
`define GPC_OFS_PIN7_CONTROL 8'h28
`define GPC_OFS_IRQ_STATUS 8'h40
`define GPC_OFS_IRQ_MASK 8'h44
// ****************************************************************
// Field positions
// ****************************************************************
`define GPC_B_FWD_MASK 25
`define GPC_B_TRIG_HI 23
`define GPC_B_TRIG_LO 21
`define GPC_B_PEND_EN 20
`define GPC_B_DRV_HI 14
`define GPC_B_DRV_LO 12
`define GPC_B_STRONG_PU 11
`define GPC_B_WEAK_PD 9
`define GPC_B_WEAK_PU 8
`define GPC_B_IN_EN 7
`define GPC_B_OUT_EN 6
`define GPC_B_SCHMITT 5
`define GPC_B_ANALOG 4
// Writable bits; reserved positions read zero and ignore writes.
`define GPC_WMASK_PIN6 32'h02F0_7BFF
`define GPC_WMASK_PIN7 32'h02F0_7BF0
// ****************************************************************
// Reset values
// ****************************************************************
`define GPC_RST_CONTROL 32'h0000_1001
`define GPC_RST_DRV 3'h1
`define GPC_FUNC_GPIO 4'h1
`define GPC_FUNC_MAX 4'h9
`define GPC_FUNC_RSVD 4'h4
`endif

// ---- src/gpc_pkg.sv ----
// Types shared by the pin control block and its trigger detector.
// Assumes nothing beyond a SystemVerilog compiler.
package gpc_pkg;
   // ****************************************************************
   // Trigger modes
   // ****************************************************************
   typedef enum logic [2:0] {
      GPC_TRIG_RISE = 3'h0,
      GPC_TRIG_FALL = 3'h1,
      GPC_TRIG_BOTH = 3'h2,
      GPC_TRIG_HIGH = 3'h3,
      GPC_TRIG_LOW = 3'h4
   } gpc_trig_t;
   // Detector state: previous pin level.
   typedef struct packed {
      logic prev;
   } gpc_det_state_t;
endpackage : gpc_pkg

// ---- src/gpc_trig_if.sv ----
// Carries one pin's sample, trigger mode and event between modules.
// Assumes both ends share the system clock.
interface gpc_trig_if;
   logic pin;
   logic [2:0] mode;
   logic event_hit;
   modport ctl (output pin, output mode, input event_hit);
   modport det (input pin, input mode, output event_hit);
endinterface : gpc_trig_if

// ---- src/gpc_trig_det.sv ----
// Trigger detector for one pin: edge or level per mode.
// Assumes the pin sample is already synchronous to i_clk_sys.
`include "gpc_cfg.svh"
module gpc_trig_det
   import gpc_pkg::*;
(
   // Clock and reset.
   input wire logic i_clk_sys,
   input wire logic i_srst,
   // Detector link.
   gpc_trig_if.det trig
);
   gpc_det_state_t s_q;
   gpc_det_state_t s_d;

   // Remember the last pin level so edges can be seen.
   always_comb begin
      s_d = s_q;
      s_d.prev = trig.pin;
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Event decode; reserved codes never fire.
   always_comb begin
      unique case (trig.mode)
         GPC_TRIG_RISE: trig.event_hit = trig.pin & ~s_q.prev;
         GPC_TRIG_FALL: trig.event_hit = ~trig.pin & s_q.prev;
         GPC_TRIG_BOTH: trig.event_hit = trig.pin ^ s_q.prev;
         GPC_TRIG_HIGH: trig.event_hit = trig.pin;
         GPC_TRIG_LOW: trig.event_hit = ~trig.pin;
         default: trig.event_hit = 1'b0;
      endcase
   end
endmodule : gpc_trig_det

// ---- src/gpc_pin_ctrl.sv ----
// Control registers, pending flags and pad controls for pins 6 and 7.
// Assumes a plain one-cycle strobe register port and synchronous pins.
`include "gpc_cfg.svh"
module gpc_pin_ctrl
   import gpc_pkg::*;
(
   // Clock and reset.
   input wire logic i_clk_sys,
   input wire logic i_srst,
   // Register port.
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   // Pad inputs.
   input wire logic [1:0] i_pin,
   // Digital output values from the selected function, index 0 is pin 6, index 1 is pin 7.
   input wire logic [1:0] i_pin_out,
   // Pad controls, index 0 is pin 6, index 1 is pin 7.
   output logic [1:0] o_pad_out,
   output logic [1:0] o_pad_oe,
   output logic [1:0] o_input_buffer_en,
   output logic [1:0] o_weak_pullup_en,
   output logic [1:0] o_weak_pulldown_en,
   output logic [1:0] o_strong_pullup_en,
   output logic [1:0] o_schmitt_input_en,
   output logic [1:0] o_analog_sel,
   output logic [5:0] o_pad_drive_level,
   output logic [3:0] o_pin_function_sel,
   output logic o_lowres_adc_input1_sel,
   output logic o_analog_supply_sel,
   // Toward the system interrupt controller.
   output logic [1:0] o_system_irq_controller,
   // Local summary interrupt.
   output logic o_irq
);
   typedef struct packed {
      logic [31:0] ctl6;
      logic [31:0] ctl7;
      logic [1:0] pend;
      logic [1:0] mask;
      logic [31:0] rdata;
   } gpc_state_t;

   gpc_state_t s_q;
   gpc_state_t s_d;
   logic [1:0] hit;

   gpc_trig_if trig6 ();
   gpc_trig_if trig7 ();

   // Control words per pin; merged writes keep reserved bits at zero.
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [31:0] wm);
      merge = (old & ~wm) | (wd & wm);
   endfunction : merge

   // Pending enable of one pin; a select on a call result is not legal.
   function automatic logic pend_en_of(input gpc_state_t s,
                                       input logic idx);
      pend_en_of = idx ? s.ctl7[`GPC_B_PEND_EN] : s.ctl6[`GPC_B_PEND_EN];
   endfunction : pend_en_of

   // ****************************************************************
   // Trigger detectors
   // ****************************************************************
   // Detectors only look at the pad when its input buffer is on.
   assign trig6.pin = i_pin[0] & s_q.ctl6[`GPC_B_IN_EN];
   assign trig7.pin = i_pin[1] & s_q.ctl7[`GPC_B_IN_EN];
   assign trig6.mode = s_q.ctl6[`GPC_B_TRIG_HI:`GPC_B_TRIG_LO];
   assign trig7.mode = s_q.ctl7[`GPC_B_TRIG_HI:`GPC_B_TRIG_LO];
   assign hit = {trig7.event_hit, trig6.event_hit};

   gpc_trig_det u_det6 (
      .i_clk_sys(i_clk_sys),
      .i_srst(i_srst),
      .trig(trig6.det)
   );

   gpc_trig_det u_det7 (
      .i_clk_sys(i_clk_sys),
      .i_srst(i_srst),
      .trig(trig7.det)
   );

   // ****************************************************************
   // Register and pending logic
   // ****************************************************************
   // Writes, write-one-to-clear of pending, and event capture.
   // An event in the clearing cycle wins so no event is lost.
   always_comb begin
      logic [31:0] ctl;
      logic [1:0] clr;
      ctl = '0;
      clr = '0;
      s_d = s_q;
      if (i_wr) begin
         unique case (i_addr)
            `GPC_OFS_PIN6_CONTROL: begin
               ctl = merge(s_q.ctl6, i_wdata, `GPC_WMASK_PIN6);
               // Reserved function codes keep the old selection.
               if (ctl[3:0] == `GPC_FUNC_RSVD ||
                   ctl[3:0] > `GPC_FUNC_MAX) begin
                  ctl[3:0] = s_q.ctl6[3:0];
               end
               s_d.ctl6 = ctl;
            end
            `GPC_OFS_PIN7_CONTROL: begin
               s_d.ctl7 = merge(s_q.ctl7, i_wdata,
                                `GPC_WMASK_PIN7);
            end
            `GPC_OFS_IRQ_STATUS: clr = i_wdata[1:0];
            `GPC_OFS_IRQ_MASK: s_d.mask = i_wdata[1:0];
            default: ;
         endcase
      end
      for (int i = 0; i < 2; i++) begin
         if (clr[i]) begin
            s_d.pend[i] = 1'b0;
         end
         // Pending only when the per-pin enable is set.
         if (hit[i] && pend_en_of(s_q, i[0])) begin
            s_d.pend[i] = 1'b1;
         end
         // A cleared enable drops any stale pending request.
         if (!pend_en_of(s_d, i[0])) begin
            s_d.pend[i] = 1'b0;
         end
      end
      // Read data stands for one cycle after the read strobe.
      s_d.rdata = '0;
      if (i_rd) begin
         unique case (i_addr)
            `GPC_OFS_PIN6_CONTROL: s_d.rdata = s_q.ctl6;
            `GPC_OFS_PIN7_CONTROL: s_d.rdata = s_q.ctl7;
            `GPC_OFS_IRQ_STATUS: s_d.rdata = {30'h0000_0000, s_q.pend};
            `GPC_OFS_IRQ_MASK: s_d.rdata = {30'h0000_0000, s_q.mask};
            default: s_d.rdata = '0;
         endcase
      end
   end

   // Reset puts drive code 1 and plain I/O function in place.
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         s_q.ctl6 <= `GPC_RST_CONTROL;
         s_q.ctl7 <= `GPC_RST_CONTROL & `GPC_WMASK_PIN7;
         s_q.pend <= '0;
         s_q.mask <= '0;
         s_q.rdata <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign o_rdata = s_q.rdata;
   // Forward a pending request only while its mask bit is 1.
   assign o_system_irq_controller[0] =
      s_q.pend[0] & s_q.ctl6[`GPC_B_FWD_MASK];
   assign o_system_irq_controller[1] =
      s_q.pend[1] & s_q.ctl7[`GPC_B_FWD_MASK];
   // Local summary line, gated by the local mask register.
   assign o_irq = |(s_q.pend & s_q.mask);

   // Pad static controls straight from the control words.
   // Pin 7 drive code sits in the upper three bits.
   assign o_pad_drive_level = {s_q.ctl7[`GPC_B_DRV_HI:`GPC_B_DRV_LO],
                               s_q.ctl6[`GPC_B_DRV_HI:`GPC_B_DRV_LO]};
   assign o_weak_pulldown_en = {s_q.ctl7[`GPC_B_WEAK_PD],
                                s_q.ctl6[`GPC_B_WEAK_PD]};
   assign o_weak_pullup_en = {s_q.ctl7[`GPC_B_WEAK_PU],
                              s_q.ctl6[`GPC_B_WEAK_PU]};
   assign o_strong_pullup_en = {s_q.ctl7[`GPC_B_STRONG_PU],
                                s_q.ctl6[`GPC_B_STRONG_PU]};
   assign o_input_buffer_en = {s_q.ctl7[`GPC_B_IN_EN],
                               s_q.ctl6[`GPC_B_IN_EN]};
   assign o_schmitt_input_en = {s_q.ctl7[`GPC_B_SCHMITT],
                                s_q.ctl6[`GPC_B_SCHMITT]};
   assign o_analog_sel = {s_q.ctl7[`GPC_B_ANALOG],
                          s_q.ctl6[`GPC_B_ANALOG]};
   assign o_analog_supply_sel = s_q.ctl6[`GPC_B_ANALOG];
   assign o_lowres_adc_input1_sel = s_q.ctl7[`GPC_B_ANALOG];
   // Function selection only matters on the digital path of pin 6.
   assign o_pin_function_sel = s_q.ctl6[3:0];
   // The driver is off while the pad is in its analog path, to avoid a
   // digital driver fighting the analog signal.
   assign o_pad_oe[0] = s_q.ctl6[`GPC_B_OUT_EN] &
                        ~s_q.ctl6[`GPC_B_ANALOG];
   assign o_pad_oe[1] = s_q.ctl7[`GPC_B_OUT_EN] &
                        ~s_q.ctl7[`GPC_B_ANALOG];
   assign o_pad_out = i_pin_out;
endmodule : gpc_pin_ctrl

// ---- verification/gpc_pin_chk.sv ----
// Checker for the pin 6/7 control block, watching its ports only.
// Assumes one clock and a synchronous active-high reset.
module gpc_pin_chk (
   // Clock, reset and register port.
   input wire logic i_clk_sys,
   input wire logic i_srst,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [31:0] o_rdata,
   // Pad controls and requests.
   input wire logic [1:0] o_pad_oe,
   input wire logic [1:0] o_input_buffer_en,
   input wire logic [1:0] o_weak_pullup_en,
   input wire logic [1:0] o_analog_sel,
   input wire logic [5:0] o_pad_drive_level,
   input wire logic [1:0] o_system_irq_controller
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************************************
   // Properties
   // ****************************************************************
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_srst);
   // A write to either control register.
   sequence s_wr6;
      i_wr && i_addr == 8'h24;
   endsequence
   sequence s_wr7;
      i_wr && i_addr == 8'h28;
   endsequence
   AST_RST: assert property ($fell(i_srst) |->
      o_pad_drive_level == 6'h09 && o_pad_oe == 2'h0) else $error("reset");
   AST_DRV6: assert property (s_wr6 |=>
      o_pad_drive_level[2:0] == $past(i_wdata[14:12])) else $error("drv6");
   AST_DRV7: assert property (s_wr7 |=>
      o_pad_drive_level[5:3] == $past(i_wdata[14:12])) else $error("drv7");
   AST_INBUF: assert property (s_wr6 |=>
      o_input_buffer_en[0] == $past(i_wdata[7])) else $error("inbuf");
   AST_OE: assert property (s_wr6 |=>
      o_pad_oe[0] == ($past(i_wdata[6]) && !$past(i_wdata[4])))
      else $error("oe");
   AST_PU: assert property (s_wr7 |=>
      o_weak_pullup_en[1] == $past(i_wdata[8])) else $error("pullup");
   // Analog path keeps the digital driver off the pad.
   AST_ANA: assert property (o_analog_sel[1] |->
      !o_pad_oe[1]) else $error("analog oe");
   AST_PEND_OFF: assert property (s_wr7 ##0 !i_wdata[20] |=>
      !o_system_irq_controller[1]) else $error("pend off");
   AST_MASK: assert property (s_wr7 ##0 !i_wdata[25] |=>
      !o_system_irq_controller[1]) else $error("mask");
   AST_UNMAP: assert property (i_rd && i_addr == 8'h30 |=>
      o_rdata == 32'h0) else $error("unmapped");
endmodule : gpc_pin_chk

bind gpc_pin_ctrl gpc_pin_chk chk_u (.*);

// ---- verification/gpc_pad_model.sv ----
// Model of the two pads: forced level, pull, or a wandering float.
// Assumes the bench changes forced levels just after a rising edge.
module gpc_pad_model (
   // Clock.
   input wire logic i_clk_sys,
   // Forced levels from the bench.
   input wire logic [1:0] i_force_en,
   input wire logic [1:0] i_force_val,
   // Pull enables from the block.
   input wire logic [1:0] i_pu,
   input wire logic [1:0] i_pd,
   // Levels seen by the block.
   output logic [1:0] o_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] float_q = 2'h1;
   // An unpulled pad toggles so it never looks like a steady level.
   always @(posedge i_clk_sys) begin
      float_q <= ~float_q;
   end
   // A forced level wins over a pull, a pull over the float.
   assign o_pin = (i_force_en & i_force_val) |
      (~i_force_en & (i_pu | (~i_pd & float_q)));
endmodule : gpc_pad_model

// ---- verification/gpio_pin_control_6_7_tb.sv ----
// Self-checking bench for the pin 6/7 control block.
// Assumes design, checker and pad model are compiled first.
module gpio_pin_control_6_7_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk_sys = 1'b0;
   logic i_srst = 1'b1;
   logic [7:0] i_addr = 8'h00;
   logic [31:0] i_wdata = 32'h0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [1:0] i_pin_out = 2'h1;
   logic [1:0] frc_val = 2'h0;
   logic [31:0] o_rdata;
   logic [1:0] i_pin, o_pad_out, o_pad_oe, o_input_buffer_en;
   logic [1:0] o_weak_pullup_en, o_weak_pulldown_en, o_strong_pullup_en;
   logic [1:0] o_schmitt_input_en, o_analog_sel, o_system_irq_controller;
   logic [5:0] o_pad_drive_level;
   logic [3:0] o_pin_function_sel;
   logic o_lowres_adc_input1_sel, o_analog_supply_sel, o_irq;
   int fails = 0;
   int n_compared = 0;
   int cyc = 0;
   logic [3:0] fn;
   logic e;
   // ****************************************************************
   // Clock, design and pads
   // ****************************************************************
   always #50 i_clk_sys = ~i_clk_sys;
   gpc_pin_ctrl dut_u (.*);
   gpc_pad_model pad_u (.i_clk_sys(i_clk_sys), .i_force_en(2'h2),
      .i_force_val(frc_val), .i_pu(o_weak_pullup_en | o_strong_pullup_en),
      .i_pd(o_weak_pulldown_en), .o_pin(i_pin));
   task automatic conclude;
      $display("compared %0d, mismatched %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : conclude
   task automatic chk(input string nm, input logic [31:0] got, x);
      n_compared++;
      if (got !== x) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, x, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rc(input logic [7:0] a, input logic [31:0] x);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1 chk("rdata", o_rdata, x);
   endtask : rc
   // Arms pin 7 at level s, clears pending, then flips the pad once.
   task automatic trig(input logic [2:0] m, input logic s,
         input logic [31:0] en, input logic [1:0] x);
      @(posedge i_clk_sys);
      frc_val <= {s, 1'b0};
      wr(8'h28, en | 32'h80 | {8'h0, m, 21'h0});
      repeat (2) @(posedge i_clk_sys);
      wr(8'h40, 32'h3);
      @(posedge i_clk_sys);
      frc_val <= {~s, 1'b0};
      repeat (2) @(posedge i_clk_sys);
      #1 chk("fwd", 32'(o_system_irq_controller[1]), 32'(x[1]));
      rc(8'h40, {30'h0, x[0], 1'b0});
   endtask : trig
   // Hang guard: the sequence needs under a thousand cycles.
   always @(posedge i_clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fails++;
         conclude();
      end
   end
   initial begin
      repeat (8) @(posedge i_clk_sys);
      i_srst <= 1'b0;
      rc(8'h24, 32'h0000_1001);
      rc(8'h28, 32'h0000_1000);
      rc(8'h44, 32'h0);
      rc(8'h30, 32'h0);
      wr(8'h24, 32'hFFFF_FFFF);
      rc(8'h24, 32'h02F0_7BF1);
      wr(8'h28, 32'hFFFF_FFFF);
      rc(8'h28, 32'h02F0_7BF0);
      // Reserved function codes must leave the last good one in place.
      fn = 4'h1;
      for (int c = 0; c < 16; c++) begin
         if (c <= 9 && c != 4) fn = c[3:0];
         wr(8'h24, 32'(c));
         chk("func", 32'(o_pin_function_sel), 32'(fn));
      end
      for (int c = 0; c < 8; c++) begin
         wr(8'h28, 32'(c) << 12);
         chk("drive", 32'(o_pad_drive_level[5:3]), 32'(c));
      end
      wr(8'h24, 32'h0000_0BE1);
      chk("pad6", 32'({o_strong_pullup_en[0], o_weak_pulldown_en[0],
         o_weak_pullup_en[0], o_input_buffer_en[0], o_pad_oe[0],
         o_schmitt_input_en[0], o_analog_supply_sel, o_pad_out}),
         32'h1F9);
      // The driven value follows the function output straight through.
      @(posedge i_clk_sys);
      i_pin_out <= 2'h2;
      @(posedge i_clk_sys);
      #1 chk("pad_out", 32'(o_pad_out), 32'h2);
      wr(8'h28, 32'h0000_0BE0);
      chk("pad7", 32'({o_strong_pullup_en[1], o_weak_pulldown_en[1],
         o_weak_pullup_en[1], o_input_buffer_en[1], o_pad_oe[1],
         o_schmitt_input_en[1], o_lowres_adc_input1_sel}),
         32'h7E);
      wr(8'h24, 32'h50);
      chk("ana6", 32'({o_pad_oe[0], o_analog_supply_sel, o_analog_sel[0]}),
         32'h3);
      wr(8'h28, 32'h10);
      chk("ana7", 32'({o_lowres_adc_input1_sel, o_analog_sel[1]}),
         32'h3);
      // Pin 6 pulled up at high level fires; pulled down it stays quiet.
      wr(8'h24, 32'h0070_0181);
      wr(8'h40, 32'h1);
      rc(8'h40, 32'h1);
      wr(8'h24, 32'h0070_0281);
      wr(8'h40, 32'h1);
      rc(8'h40, 32'h0);
      for (int m = 0; m < 8; m++) begin
         for (int s = 0; s < 2; s++) begin
            e = (m == 0) ? s == 0 : (m == 1) ? s == 1 : m < 5;
            trig(m[2:0], s[0], 32'h0210_0000, {e, e});
         end
      end
      trig(3'h0, 1'b0, 32'h0010_0000, 2'b01);
      chk("irq", 32'(o_irq), 32'h0);
      wr(8'h44, 32'h2);
      chk("irq", 32'(o_irq), 32'h1);
      wr(8'h40, 32'h2);
      chk("irq", 32'(o_irq), 32'h0);
      trig(3'h0, 1'b0, 32'h0200_0000, 2'b00);
      // A reset in mid-run must bring back the reset values of both control registers.
      @(posedge i_clk_sys);
      i_srst <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      i_srst <= 1'b0;
      rc(8'h28, 32'h0000_1000);
      rc(8'h24, 32'h0000_1001);
      conclude();
   end
endmodule : gpio_pin_control_6_7_tb
